//--- rtl/rx_decode_readout_regs.sv
`include "rx_readout_cfg.svh"
`default_nettype none
module rx_decode_readout_regs #(
    parameter int WORD_WIDTH = `RX_WORD_WIDTH,
    parameter int CW = `REPEAT_COUNT_WIDTH
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic rd_en_i,
    input wire logic [`ADDR_WIDTH-1:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic repeat_clear_i,
    input wire logic repeat_valid_i,
    input wire logic [WORD_WIDTH-1:0] repeat_word_i,
    input wire logic decode_done_i,
    input wire logic [3:0] corrected_nibble_i,
    input wire logic [1:0] parity_errors_i,
    input wire logic [1:0] data_fixes_i,
    input wire logic uncorrectable_i,
    input wire logic adc_done_i,
    input wire logic [7:0] adc_data_i,
    input wire logic tone_valid_i,
    input wire logic [7:0] tone_offset_hz_i
);
    ////////////////////////////////////////////////////////////////////////////
    logic [WORD_WIDTH-1:0] voted;
    logic [CW-1:0] tally_count;
    logic [6:0] erased_count;

    vote_tally #(
        .WIDTH(WORD_WIDTH),
        .CW(CW)
    ) u_tally (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clear_i(repeat_clear_i),
        .word_valid_i(repeat_valid_i),
        .word_i(repeat_word_i),
        .voted_o(voted),
        .repeat_count_o(tally_count),
        .erased_count_o(erased_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // only legal codes come out of this function; any mix beyond them is a failure
    function automatic rx_readout_pkg::decode_status_type encode_status(
        input logic [1:0] par,
        input logic [1:0] fix,
        input logic fail,
        input logic many_erased
    );
        rx_readout_pkg::decode_status_type s;
        s = rx_readout_pkg::status_failed;
        if (fail || par == 2'h3 || fix == 2'h3) begin
            s = rx_readout_pkg::status_failed;
        end else if (many_erased) begin
            unique case (par)
                2'h0: s = rx_readout_pkg::status_erase;
                2'h1: s = (fix > 2'h1) ? rx_readout_pkg::status_failed : rx_readout_pkg::status_erase_par1;
                default: s = (fix != 2'h0) ? rx_readout_pkg::status_failed : rx_readout_pkg::status_erase_par2;
            endcase
        end else if (fix == 2'h0) begin
            unique case (par)
                2'h0: s = rx_readout_pkg::status_clean;
                2'h1: s = rx_readout_pkg::status_par1;
                default: s = rx_readout_pkg::status_par2;
            endcase
        end else if (fix == 2'h1 && par == 2'h0) begin
            s = rx_readout_pkg::status_fix1;
        end else if (fix == 2'h1 && par == 2'h1) begin
            s = rx_readout_pkg::status_fix1_par1;
        end else if (fix == 2'h2 && par == 2'h0) begin
            s = rx_readout_pkg::status_fix2;
        end
        return s;
    endfunction : encode_status

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] nibble;
    logic [3:0] next_nibble;
    rx_readout_pkg::decode_status_type status;
    rx_readout_pkg::decode_status_type next_status;
    logic [WORD_WIDTH-1:0] uncorrected;
    logic [WORD_WIDTH-1:0] next_uncorrected;
    logic [7:0] repeat_count;
    logic [7:0] next_repeat_count;
    logic [7:0] adc_result;
    logic [7:0] next_adc_result;
    logic [7:0] tone_code;
    logic [7:0] next_tone_code;
    rx_readout_pkg::decode_status_type new_status;

    assign new_status = encode_status(parity_errors_i, data_fixes_i, uncorrectable_i,
        erased_count > 7'(`ERASURE_LIMIT));

    always_comb begin
        next_nibble = nibble;
        next_status = status;
        next_uncorrected = uncorrected;
        next_repeat_count = repeat_count;
        next_adc_result = adc_result;
        next_tone_code = tone_code;
        if (decode_done_i) begin
            next_status = new_status;
            // a failed decode reports the raw voted data bits, not the engine's guess
            if (new_status == rx_readout_pkg::status_failed) begin
                next_nibble = voted[`DATA_LSB_POS +: 4];
            end else begin
                next_nibble = corrected_nibble_i;
            end
            next_uncorrected = voted;
            next_repeat_count = 8'(tally_count);
        end
        if (adc_done_i) begin
            next_adc_result = adc_data_i;
        end
        if (tone_valid_i) begin
            // the listed codes sit one step below the plain offset from 6 kHz
            next_tone_code = tone_offset_hz_i - 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            nibble <= 4'h0;
            status <= rx_readout_pkg::status_clean;
            uncorrected <= `RESET_WORD;
            repeat_count <= `RESET_BYTE;
            adc_result <= `RESET_BYTE;
            tone_code <= `RESET_BYTE;
        end else begin
            nibble <= next_nibble;
            status <= next_status;
            uncorrected <= next_uncorrected;
            repeat_count <= next_repeat_count;
            adc_result <= next_adc_result;
            tone_code <= next_tone_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data registered one cycle after the strobe, unmapped reads return zero
    logic [7:0] next_rd_data;
    logic next_rd_valid;

    always_comb begin
        next_rd_valid = rd_en_i;
        next_rd_data = rd_data_o;
        if (rd_en_i) begin
            unique case (rd_addr_i)
                `ADDR_RX_WORD3: next_rd_data = {nibble, status};
                `ADDR_UNCORR_W0: next_rd_data = uncorrected[39:32];
                `ADDR_UNCORR_W1: next_rd_data = uncorrected[31:24];
                `ADDR_UNCORR_W2: next_rd_data = uncorrected[23:16];
                `ADDR_UNCORR_W3: next_rd_data = uncorrected[15:8];
                `ADDR_UNCORR_W4: next_rd_data = uncorrected[7:0];
                `ADDR_REPEAT_COUNT: next_rd_data = repeat_count;
                `ADDR_ADC_RESULT: next_rd_data = adc_result;
                `ADDR_TONE_OFFSET: next_rd_data = tone_code;
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_data_o <= next_rd_data;
            rd_valid_o <= next_rd_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_status_legal: assert property (!(status inside {4'h3, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB}))
        else $error("unused decode status code");
    a_status_clean: assert property (decode_done_i && !uncorrectable_i && parity_errors_i == 2'h0 &&
        data_fixes_i == 2'h0 && erased_count <= 7'h02 |=> status == 4'h0)
        else $error("clean word not reported as 0000");
    a_status_fix_par: assert property (decode_done_i && !uncorrectable_i && parity_errors_i == 2'h1 &&
        data_fixes_i == 2'h1 && erased_count <= 7'h02 |=> status == 4'h5)
        else $error("fix with parity error not 0101");
    a_status_erase: assert property (decode_done_i && !uncorrectable_i && erased_count > 7'h02 &&
        parity_errors_i == 2'h2 && data_fixes_i == 2'h0 |=> status == 4'hE)
        else $error("erasure with two parity errors not 1110");
    a_failed_raw: assert property (decode_done_i && uncorrectable_i |=>
        status == 4'hF && nibble == $past(voted[15:12]))
        else $error("failed decode not reported raw");
    // read data shows the state before any update at the strobe edge, hence the past value
    a_word3_read: assert property (rd_en_i && rd_addr_i == 7'h13 |=>
        rd_valid_o && rd_data_o == $past({nibble, status}))
        else $error("word 3 read wrong");
    a_msb_first: assert property (rd_en_i && rd_addr_i == 7'h18 |=> rd_data_o == $past(uncorrected[39:32]))
        else $error("uncorrected top byte not at lowest address");
    a_lsb_last: assert property (rd_en_i && rd_addr_i == 7'h1C |=> rd_data_o == $past(uncorrected[7:0]))
        else $error("uncorrected bottom byte not at highest address");
    a_repeat_latch: assert property (decode_done_i |=> repeat_count == 8'($past(tally_count)))
        else $error("repeat count not latched");
    a_adc_hold: assert property (adc_done_i ##1 !adc_done_i [*3] |-> adc_result == $past(adc_data_i, 3))
        else $error("adc result not held");
    a_tone_code: assert property (tone_valid_i && tone_offset_hz_i == 8'h04 |=> tone_code == 8'h03)
        else $error("tone code for +4 Hz wrong");

    c_failed: cover property (decode_done_i && uncorrectable_i);
    c_erasure: cover property (decode_done_i && erased_count > 7'h02);
    c_adc_then_read: cover property (adc_done_i ##[1:4] rd_en_i && rd_addr_i == 7'h20);
    c_tone_read: cover property (tone_valid_i ##[1:4] rd_en_i && rd_addr_i == 7'h30);

endmodule : rx_decode_readout_regs
`default_nettype wire

//--- rtl/rx_readout_cfg.svh
`ifndef RX_READOUT_CFG_SVH
`define RX_READOUT_CFG_SVH

// read address map, 7-bit addresses
`define ADDR_WIDTH 7
`define ADDR_RX_WORD3 7'h13
`define ADDR_UNCORR_W0 7'h18
`define ADDR_UNCORR_W1 7'h19
`define ADDR_UNCORR_W2 7'h1A
`define ADDR_UNCORR_W3 7'h1B
`define ADDR_UNCORR_W4 7'h1C
`define ADDR_REPEAT_COUNT 7'h1D
`define ADDR_ADC_RESULT 7'h20
`define ADDR_TONE_OFFSET 7'h30

// field layout
`define RX_WORD_WIDTH 40
`define PARITY_BITS 12
`define REPEAT_COUNT_WIDTH 4
`define DATA_LSB_POS 12
`define ERASURE_LIMIT 2

// reset values of the result registers
`define RESET_BYTE 8'h00
`define RESET_WORD 40'h00_0000_0000

`endif

//--- rtl/rx_readout_pkg.sv
`default_nettype none
package rx_readout_pkg;

    typedef enum logic [3:0] {
        status_clean = 4'b0000,
        status_par1 = 4'b0001,
        status_par2 = 4'b0010,
        status_fix1 = 4'b0100,
        status_fix1_par1 = 4'b0101,
        status_fix2 = 4'b1000,
        status_erase = 4'b1100,
        status_erase_par1 = 4'b1101,
        status_erase_par2 = 4'b1110,
        status_failed = 4'b1111
    } decode_status_type;

endpackage : rx_readout_pkg
`default_nettype wire

//--- rtl/vote_tally.sv
`include "rx_readout_cfg.svh"
`default_nettype none
module vote_tally #(
    parameter int WIDTH = `RX_WORD_WIDTH,
    parameter int CW = `REPEAT_COUNT_WIDTH
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic word_valid_i,
    input wire logic [WIDTH-1:0] word_i,
    output logic [WIDTH-1:0] voted_o,
    output logic [CW-1:0] repeat_count_o,
    output logic [6:0] erased_count_o
);
    logic [CW-1:0] ones [WIDTH];
    logic [CW-1:0] next_ones [WIDTH];
    logic [CW-1:0] repeat_count;
    logic [CW-1:0] next_repeat_count;
    logic [WIDTH-1:0] erased;
    logic at_limit;

    // saturating count: once full, further repeats are dropped so votes stay consistent
    assign at_limit = &repeat_count;

    always_comb begin
        next_repeat_count = repeat_count;
        if (clear_i) begin
            next_repeat_count = '0;
        end else if (word_valid_i && !at_limit) begin
            next_repeat_count = repeat_count + 1'b1;
        end
    end

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_comb begin
                next_ones[b] = ones[b];
                if (clear_i) begin
                    next_ones[b] = '0;
                end else if (word_valid_i && !at_limit && word_i[b]) begin
                    next_ones[b] = ones[b] + 1'b1;
                end
            end

            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    ones[b] <= '0;
                end else begin
                    ones[b] <= next_ones[b];
                end
            end

            // twice the ones against the repeat count: more wins, equal to a nonzero count means erased
            assign voted_o[b] = {ones[b], 1'b0} > {1'b0, repeat_count};
            assign erased[b] = (repeat_count != '0) && ({ones[b], 1'b0} == {1'b0, repeat_count});
        end
    endgenerate

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            repeat_count <= '0;
        end else begin
            repeat_count <= next_repeat_count;
        end
    end

    always_comb begin
        erased_count_o = '0;
        for (int i = 0; i < WIDTH; i++) begin
            erased_count_o = erased_count_o + 7'(erased[i]);
        end
    end

    assign repeat_count_o = repeat_count;

    a_erase_tie: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (repeat_count == 4'h2 && ones[0] == 4'h1) |-> erased[0] && !voted_o[0])
        else $error("tied bit not flagged as erased");

endmodule : vote_tally
`default_nettype wire

//--- testbench/host_reader.sv
`include "rx_readout_cfg.svh"
`default_nettype none
module host_reader (
    input wire logic clock_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_en_o,
    output logic [`ADDR_WIDTH-1:0] rd_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_en_o = 1'b0;
        rd_addr_o = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one strobe per read, answer taken at the edge after the one that samples the strobe
    task automatic read_reg(input logic [`ADDR_WIDTH-1:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clock_i);
        rd_en_o <= 1'b1;
        rd_addr_o <= addr;
        @(posedge clock_i);
        rd_en_o <= 1'b0;
        // released address is scrambled so a stale one cannot pass
        rd_addr_o <= ~addr;
        @(posedge clock_i);
        ok = rd_valid_i;
        data = rd_data_i;
    endtask : read_reg
endmodule : host_reader
`default_nettype wire

//--- testbench/tb_rx_decode_readout_regs.sv
`include "rx_readout_cfg.svh"
`default_nettype none
module tb_rx_decode_readout_regs;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [39:0] diff;
        logic [1:0] par;
        logic [1:0] fix;
        logic fail;
        logic [3:0] status;
    } row_type;

    localparam logic [39:0] BASE = 40'hA5C396E17B;
    localparam logic [39:0] TIE3 = 40'h0000007000;
    localparam row_type ROWS [15] = '{
        '{40'h0, 2'h0, 2'h0, 1'b0, 4'h0}, '{40'h0, 2'h1, 2'h0, 1'b0, 4'h1}, '{40'h0, 2'h2, 2'h0, 1'b0, 4'h2},
        '{40'h0, 2'h0, 2'h1, 1'b0, 4'h4}, '{40'h0, 2'h1, 2'h1, 1'b0, 4'h5}, '{40'h0, 2'h0, 2'h2, 1'b0, 4'h8},
        '{40'h0, 2'h0, 2'h0, 1'b1, 4'hF}, '{40'h0, 2'h2, 2'h1, 1'b0, 4'hF}, '{40'h0, 2'h1, 2'h2, 1'b0, 4'hF},
        '{40'h0, 2'h3, 2'h0, 1'b0, 4'hF}, '{40'h0000003000, 2'h0, 2'h0, 1'b0, 4'h0},
        '{TIE3, 2'h0, 2'h0, 1'b0, 4'hC}, '{TIE3, 2'h1, 2'h0, 1'b0, 4'hD}, '{TIE3, 2'h2, 2'h0, 1'b0, 4'hE},
        '{TIE3, 2'h2, 2'h1, 1'b0, 4'hF}
    };
    localparam logic [6:0] MAP [9] = '{`ADDR_RX_WORD3, `ADDR_UNCORR_W0, `ADDR_UNCORR_W1, `ADDR_UNCORR_W2,
        `ADDR_UNCORR_W3, `ADDR_UNCORR_W4, `ADDR_REPEAT_COUNT, `ADDR_ADC_RESULT, `ADDR_TONE_OFFSET};
    localparam logic [7:0] TONE_IN [4] = '{8'h04, 8'h00, 8'hFC, 8'h7F};
    localparam logic [7:0] TONE_OUT [4] = '{8'h03, 8'hFF, 8'hFB, 8'h7E};

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rd_en;
    logic rd_valid;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic repeat_clear = 1'b0, repeat_valid = 1'b0, decode_done = 1'b0, fail = 1'b0;
    logic adc_done = 1'b0, tone_valid = 1'b0;
    logic [39:0] repeat_word = 40'h0;
    logic [3:0] nibble = 4'h0;
    logic [1:0] par = 2'h0, fix = 2'h0;
    logic [7:0] adc_data = 8'h00, tone_hz = 8'h00;
    int fail_count = 0, check_count = 0, cycles = 0;

    always #20 clock = ~clock;

    rx_decode_readout_regs dut_u (.clock_i(clock), .reset_n_i(reset_n), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .repeat_clear_i(repeat_clear), .repeat_valid_i(repeat_valid),
        .repeat_word_i(repeat_word), .decode_done_i(decode_done), .corrected_nibble_i(nibble),
        .parity_errors_i(par), .data_fixes_i(fix), .uncorrectable_i(fail), .adc_done_i(adc_done),
        .adc_data_i(adc_data), .tone_valid_i(tone_valid), .tone_offset_hz_i(tone_hz));

    host_reader host_u (.clock_i(clock), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .rd_en_o(rd_en),
        .rd_addr_o(rd_addr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic read_check(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.read_reg(addr, d, ok);
        check8({7'h00, ok}, 8'h01);
        check8(d, exp);
    endtask : read_check

    // odd repeats carry the flipped bits, so two repeats tie on every diff bit
    task automatic load(input logic [39:0] w, input int reps, input row_type r, input logic [3:0] n);
        @(posedge clock);
        repeat_clear <= 1'b1;
        for (int k = 0; k < reps; k++) begin
            @(posedge clock);
            repeat_clear <= 1'b0;
            repeat_valid <= 1'b1;
            repeat_word <= k[0] ? w ^ r.diff : w;
        end
        @(posedge clock);
        repeat_valid <= 1'b0;
        repeat_word <= ~w;
        par <= r.par;
        fix <= r.fix;
        fail <= r.fail;
        nibble <= n;
        decode_done <= 1'b1;
        @(posedge clock);
        decode_done <= 1'b0;
        nibble <= ~n;
    endtask : load

    task automatic check_word(input logic [39:0] v);
        for (int k = 0; k < 5; k++) begin
            read_check(7'(`ADDR_UNCORR_W0 + k), v[39 - 8 * k -: 8]);
        end
    endtask : check_word

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [39:0] v;
        logic [3:0] nb;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        foreach (MAP[i]) read_check(MAP[i], 8'h00);
        $display("test reset done");
        foreach (ROWS[i]) begin
            nb = 4'h9 ^ 4'(i);
            v = BASE & ~ROWS[i].diff;
            load(BASE, 2, ROWS[i], nb);
            read_check(`ADDR_RX_WORD3, {ROWS[i].status == 4'hF ? v[15:12] : nb, ROWS[i].status});
            check_word(v);
            read_check(`ADDR_REPEAT_COUNT, 8'h02);
            $display("test row %0d done", i);
        end
        // three repeats: one dissenter per diff bit loses the vote, no ties
        load(BASE, 3, '{40'hFF000000FF, 2'h0, 2'h0, 1'b0, 4'h0}, 4'h6);
        read_check(`ADDR_RX_WORD3, 8'h60);
        check_word(BASE);
        read_check(`ADDR_REPEAT_COUNT, 8'h03);
        load(BASE, 17, '{40'hFF000000FF, 2'h0, 2'h0, 1'b0, 4'h0}, 4'h6);
        read_check(`ADDR_REPEAT_COUNT, 8'h0F);
        $display("test majority done");
        @(posedge clock);
        adc_data <= 8'h9C;
        adc_done <= 1'b1;
        @(posedge clock);
        adc_done <= 1'b0;
        adc_data <= 8'h63;
        // read only once the done pulse has ended and the input has moved on
        read_check(`ADDR_ADC_RESULT, 8'h9C);
        foreach (TONE_IN[i]) begin
            @(posedge clock);
            tone_hz <= TONE_IN[i];
            tone_valid <= 1'b1;
            @(posedge clock);
            tone_valid <= 1'b0;
            tone_hz <= ~TONE_IN[i];
            read_check(`ADDR_TONE_OFFSET, TONE_OUT[i]);
        end
        $display("test adc and tone done");
        read_check(7'h14, 8'h00);
        read_check(7'h7F, 8'h00);
        $display("test unmapped done");
        // registers hold nonzero results here, so a mid-run reset must visibly clear them
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        foreach (MAP[i]) read_check(MAP[i], 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb_rx_decode_readout_regs
`default_nettype wire
